// ---- src/fdmu_pkg.sv ----
// constants and types shared by the divide/multiply/add datapath
package fdmu_pkg;

  // ------------------------------------------------------------------
  // instruction encoding
  // ------------------------------------------------------------------
  localparam logic [5:0] OP_DOUBLE  = 6'h3F;
  localparam logic [5:0] OP_SINGLE  = 6'h3B;
  localparam logic [4:0] XO_DIV     = 5'h12;
  localparam logic [4:0] XO_MUL     = 5'h19;
  localparam logic [4:0] XO_MSUB    = 5'h1C;
  localparam logic [4:0] XO_MADD    = 5'h1D;
  localparam logic [9:0] XO_MOVE    = 10'h048;
  localparam logic [4:0] FIELD_ZERO = 5'h00;

  // ------------------------------------------------------------------
  // status and control register layout
  // ------------------------------------------------------------------
  localparam int FX_BIT   = 31;
  localparam int FEX_BIT  = 30;
  localparam int VX_BIT   = 29;
  localparam int OX_BIT   = 28;
  localparam int ZX_BIT   = 26;
  localparam int RESULT_CLASS_FLAGS_LSB = 12;
  localparam int VE_BIT   = 7;
  localparam int ZE_BIT   = 4;
  localparam logic [31:0] FP_STATUS_CONTROL_REG_RESET = 32'h0000_0000;
  localparam logic [1:0]  RN_NEAR = 2'h0;
  localparam logic [1:0]  RN_ZERO = 2'h1;
  localparam logic [1:0]  RN_PINF = 2'h2;
  localparam logic [1:0]  RN_MINF = 2'h3;

  // ------------------------------------------------------------------
  // result classes
  // ------------------------------------------------------------------
  localparam logic [4:0] CL_QNAN  = 5'h11;
  localparam logic [4:0] CL_NINF  = 5'h09;
  localparam logic [4:0] CL_NNORM = 5'h08;
  localparam logic [4:0] CL_NDEN  = 5'h18;
  localparam logic [4:0] CL_NZERO = 5'h12;
  localparam logic [4:0] CL_PZERO = 5'h02;
  localparam logic [4:0] CL_PDEN  = 5'h14;
  localparam logic [4:0] CL_PNORM = 5'h04;
  localparam logic [4:0] CL_PINF  = 5'h05;

  // ------------------------------------------------------------------
  // register port map and widths
  // ------------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam int FPR_AW = 5;
  localparam int FPR_DW = 64;
  localparam logic [7:0] REG_FP_STATUS_CONTROL_REG  = 8'h00;
  localparam logic [7:0] REG_COND   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // ------------------------------------------------------------------
  // number format
  // ------------------------------------------------------------------
  localparam logic [10:0] EXP_ALL1 = 11'h7FF;
  localparam logic signed [13:0] BIAS    = 14'sh03FF;
  localparam logic signed [13:0] EMAX_DP = 14'sh03FF;
  localparam logic signed [13:0] EMIN_DP = -14'sh03FE;
  localparam logic signed [13:0] EMAX_SP = 14'sh007F;
  localparam logic signed [13:0] EMIN_SP = -14'sh007E;
  localparam logic [63:0] QNAN_DEFAULT = 64'h7FF8_0000_0000_0000;
  localparam logic [53:0] SP_ULP       = 54'h00_0000_2000_0000;
  localparam logic [63:0] MAX_DP       = 64'h7FEF_FFFF_FFFF_FFFF;
  localparam logic [63:0] MAX_SP       = 64'h47EF_FFFF_E000_0000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RDA  = 5'b00010,
    ST_RDB  = 5'b00100,
    ST_RDC  = 5'b01000,
    ST_EXEC = 5'b10000
  } fdmu_state_type;

endpackage

// ---- src/fdmu_fpr_mem.sv ----
// floating-point register file, one write port, one registered read port
`timescale 1ns/1ns
module fdmu_fpr_mem (
  input  wire  logic                           clk,     // core clock
  input  wire  logic                           wr_en,   // write strobe
  input  wire  logic [fdmu_pkg::FPR_AW-1:0]    wr_idx,  // write index
  input  wire  logic [fdmu_pkg::FPR_DW-1:0]    wr_data, // write data
  input  wire  logic [fdmu_pkg::FPR_AW-1:0]    rd_idx,  // read index
  output logic       [fdmu_pkg::FPR_DW-1:0]    rd_data  // read data, next cycle
);
  import fdmu_pkg::*;

  logic [FPR_DW-1:0] mem_reg [0:(1<<FPR_AW)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
    rd_data <= mem_reg[rd_idx];
  end

endmodule

// ---- src/fdmu_unit.sv ----
// floating-point divide / multiply / multiply-add / move datapath
`timescale 1ns/1ns
module fdmu_unit (
  input  wire  logic                          clk,           // core clock
  input  wire  logic                          rst_b,         // sync reset
  input  wire  logic                          issue_valid,   // instr offered
  input  wire  logic [31:0]                   issue_instr,   // instr word
  output logic                                issue_ready,   // idle, takes
  input  wire  logic                          fpr_load_en,   // preload
  input  wire  logic [fdmu_pkg::FPR_AW-1:0]   fpr_load_idx,  // preload idx
  input  wire  logic [fdmu_pkg::FPR_DW-1:0]   fpr_load_data, // preload data
  input  wire  logic [fdmu_pkg::REG_AW-1:0]   reg_addr,      // reg address
  input  wire  logic [31:0]                   reg_wdata,     // reg wdata
  input  wire  logic                          reg_wr,        // write strobe
  input  wire  logic                          reg_rd,        // read strobe
  output logic       [31:0]                   reg_rdata,     // read data
  output logic                                wb_valid,      // target wrote
  output logic       [fdmu_pkg::FPR_AW-1:0]   wb_idx,        // target index
  output logic       [fdmu_pkg::FPR_DW-1:0]   wb_data,       // target value
  output logic       [3:0]                    condition_field_one, // cf1
  output logic                                illegal_op     // bad encoding
);
  import fdmu_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    fdmu_state_type st;
    logic [31:0]    instr;
    logic [63:0]    opa;
    logic [63:0]    opb;
    logic [63:0]    opc;
    logic [31:0]    fp_status_control_reg;
    logic [3:0]     cf1;
    logic [31:0]    rdata;
    logic           ready;
    logic           wbv;
    logic [4:0]     wbi;
    logic [63:0]    wbd;
    logic           ill;
  } fdmu_regs_type;

  fdmu_regs_type r_reg, r_next;
  logic [4:0]  rd_idx;
  logic [63:0] rd_data;
  logic        mem_we;
  logic [4:0]  mem_wi;
  logic [63:0] mem_wd;

  fdmu_fpr_mem u_fpr (
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_idx  (mem_wi),
    .wr_data (mem_wd),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // right shift keeping lost bits as sticky in bit 0
  function automatic logic [65:0] shr_st(input logic [65:0] x,
                                         input logic signed [13:0] d);
    logic [65:0] y;
    y = x;
    if (d > 14'sd65) begin
      y = {65'h0, |x};
    end else if (d > 14'sd0) begin
      y = x >> d;
      y[0] = y[0] | (|(x & ~({66{1'b1}} << d)));
    end
    return y;
  endfunction

  // normalise, round and pack; bit 63 of m weighs 2**e; {ovf,result}
  function automatic logic [64:0] pack(input logic s,
                                       input logic signed [13:0] e,
                                       input logic [65:0] m,
                                       input logic sp,
                                       input logic [1:0] rn);
    logic [6:0]  k;
    logic [65:0] n;
    logic [53:0] q;
    logic        g, st, lsb, inc, big;
    logic signed [13:0] en;
    logic [64:0] res;
    k = 7'h00;
    for (int i = 0; i < 66; i++) begin
      if (m[i]) k = 7'(i);
    end
    n = m << (7'd65 - k);
    en = e + 14'(k) - 14'sd63;
    g   = sp ? n[41] : n[12];
    st  = sp ? |n[40:0] : |n[11:0];
    lsb = sp ? n[42] : n[13];
    case (rn)
      RN_NEAR: inc = g & (st | lsb);
      RN_ZERO: inc = 1'b0;
      RN_PINF: inc = ~s & (g | st);
      default: inc = s & (g | st);
    endcase
    q = {1'b0, n[65:13]};
    if (sp) q[28:0] = 29'h0;
    if (inc) q = q + (sp ? SP_ULP : 54'h1);
    if (q[53]) begin
      q = q >> 1;
      en = en + 14'sd1;
    end
    big = (rn == RN_NEAR) || (rn == RN_PINF && !s) || (rn == RN_MINF && s);
    if (m == 66'h0 || en < (sp ? EMIN_SP : EMIN_DP)) begin
      res = {1'b0, s, 63'h0};
    end else if (en > (sp ? EMAX_SP : EMAX_DP)) begin
      res = big ? {1'b1, s, EXP_ALL1, 52'h0}
                : {1'b1, s, (sp ? MAX_SP[62:0] : MAX_DP[62:0])};
    end else begin
      res = {1'b0, s, 11'(en + BIAS), q[51:0]};
    end
    return res;
  endfunction

  function automatic logic [4:0] fclass(input logic [63:0] x);
    logic [4:0] c;
    if (x[62:52] == EXP_ALL1) begin
      c = (x[51:0] != 52'h0) ? CL_QNAN : (x[63] ? CL_NINF : CL_PINF);
    end else if (x[62:52] == 11'h0) begin
      if (x[51:0] == 52'h0) c = x[63] ? CL_NZERO : CL_PZERO;
      else c = x[63] ? CL_NDEN : CL_PDEN;
    end else begin
      c = x[63] ? CL_NNORM : CL_PNORM;
    end
    return c;
  endfunction

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  logic [5:0] f_op;
  logic [4:0] f_d, f_a, f_b, f_c, f_xo;
  logic       f_rc, is_div, is_mul, is_fma, is_sub, is_mov, is_sp, legal;
  assign f_op = r_reg.instr[31:26];
  assign f_d  = r_reg.instr[25:21];
  assign f_a  = r_next.instr[20:16];
  assign f_b  = r_next.instr[15:11];
  assign f_c  = r_next.instr[10:6];
  assign f_xo = r_reg.instr[5:1];
  assign f_rc = r_reg.instr[0];
  assign is_sp  = f_op == OP_SINGLE;
  assign is_div = (f_xo == XO_DIV) && (r_reg.instr[10:6] == FIELD_ZERO);
  assign is_mul = (f_xo == XO_MUL) && (r_reg.instr[15:11] == FIELD_ZERO);
  assign is_fma = (f_xo == XO_MADD) || (f_xo == XO_MSUB);
  assign is_sub = f_xo == XO_MSUB;
  assign is_mov = !is_sp && (r_reg.instr[10:1] == XO_MOVE);

  logic [5:0] i_op;
  logic [4:0] i_xo;
  assign i_op = issue_instr[31:26];
  assign i_xo = issue_instr[5:1];
  assign legal = ((i_op == OP_DOUBLE) || (i_op == OP_SINGLE)) &&
                 (((i_xo == XO_DIV) && issue_instr[10:6] == FIELD_ZERO) ||
                  ((i_xo == XO_MUL) && issue_instr[15:11] == FIELD_ZERO) ||
                  (i_xo == XO_MADD) || (i_xo == XO_MSUB) ||
                  ((i_op == OP_DOUBLE) && issue_instr[10:1] == XO_MOVE));

  // ------------------------------------------------------------------
  // arithmetic
  // ------------------------------------------------------------------
  logic [10:0]  ea, eb, ec;
  logic         za, zb, zc, ia, ib, ic, na, nb, nc, sa, sb, sc;
  logic [52:0]  ma, mb, mc, mbd;
  logic signed [13:0] ua, ub, uc, ep, d, ex;
  logic [105:0] prod;
  logic [115:0] quo, rem;
  logic [65:0]  pm, bm, big_m, sml_m, sum;
  logic         s_p, s_b, s_big, s_sml, s_res, inv, zdiv, trap, ovf;
  logic [64:0]  pk;
  logic [63:0]  res;

  assign {sa, ea} = {r_reg.opa[63], r_reg.opa[62:52]};
  assign {sb, eb} = {r_reg.opb[63], r_reg.opb[62:52]};
  assign {sc, ec} = {r_reg.opc[63], r_reg.opc[62:52]};
  // subnormal sources are taken as zero
  assign za = ea == 11'h0;
  assign zb = eb == 11'h0;
  assign zc = ec == 11'h0;
  assign ia = ea == EXP_ALL1 && r_reg.opa[51:0] == 52'h0;
  assign ib = eb == EXP_ALL1 && r_reg.opb[51:0] == 52'h0;
  assign ic = ec == EXP_ALL1 && r_reg.opc[51:0] == 52'h0;
  assign na = ea == EXP_ALL1 && r_reg.opa[51:0] != 52'h0;
  assign nb = eb == EXP_ALL1 && r_reg.opb[51:0] != 52'h0;
  assign nc = ec == EXP_ALL1 && r_reg.opc[51:0] != 52'h0;
  assign ma = za ? 53'h0 : {1'b1, r_reg.opa[51:0]};
  assign mb = zb ? 53'h0 : {1'b1, r_reg.opb[51:0]};
  assign mc = zc ? 53'h0 : {1'b1, r_reg.opc[51:0]};
  assign mbd = zb ? 53'h1 : mb;
  assign ua = 14'(ea) - BIAS;
  assign ub = 14'(eb) - BIAS;
  assign uc = 14'(ec) - BIAS;

  assign prod = ma * mc;
  assign ep   = ua + uc;
  assign quo  = {ma, 63'h0} / {63'h0, mbd};
  // remainder only feeds the sticky bit
  assign rem  = {ma, 63'h0} % {63'h0, mbd};

  // product plus addend, aligned on the larger exponent
  assign s_p = sa ^ sc;
  assign s_b = sb ^ is_sub;
  assign pm  = {1'b0, prod[105:42], |prod[41:0]};
  assign bm  = {2'h0, mb, 11'h0};
  assign d   = ep - ub;

  always_comb begin
    if (d >= 14'sd0) begin
      big_m = pm;
      sml_m = shr_st(bm, d);
      s_big = s_p;
      s_sml = s_b;
    end else begin
      big_m = bm;
      sml_m = shr_st(pm, -d);
      s_big = s_b;
      s_sml = s_p;
    end
    if (s_big == s_sml) begin
      sum   = big_m + sml_m;
      s_res = s_big;
    end else if (big_m >= sml_m) begin
      sum   = big_m - sml_m;
      s_res = (sum == 66'h0) ? (r_reg.fp_status_control_reg[1:0] == RN_MINF)
                             : s_big;
    end else begin
      sum   = sml_m - big_m;
      s_res = s_sml;
    end
  end

  always_comb begin
    ex = (d >= 14'sd0) ? ep : ub;
    // single forms round to single range
    if (is_div) begin
      pk = pack(sa ^ sb, ua - ub - 14'sd1, {quo[64:0], rem != 116'h0},
                is_sp, r_reg.fp_status_control_reg[1:0]);
    end else if (is_fma) begin
      pk = pack(s_res, ex, sum, is_sp, r_reg.fp_status_control_reg[1:0]);
    end else begin
      pk = pack(s_p, ep, pm, is_sp, r_reg.fp_status_control_reg[1:0]);
    end
    inv  = (na && !r_reg.opa[51]) || (nc && !r_reg.opc[51] && !is_div) ||
           (nb && !r_reg.opb[51] && !is_mul);
    zdiv = 1'b0;
    ovf  = 1'b0;
    if (na || (nb && !is_mul) || (nc && !is_div)) begin
      res = na ? r_reg.opa : ((nb && !is_mul) ? r_reg.opb : r_reg.opc);
      res[51] = 1'b1;
    end else if (is_div) begin
      inv  = (za && zb) || (ia && ib);
      zdiv = zb && !za && !ia;
      if (inv) res = QNAN_DEFAULT;
      else if (ia || zdiv) res = {sa ^ sb, EXP_ALL1, 52'h0};
      else if (ib || za) res = {sa ^ sb, 63'h0};
      else {ovf, res} = pk;
    end else begin
      inv = ((ia || ic) && (za || zc)) ||
            (is_fma && (ia || ic) && ib && (s_p != s_b));
      if (inv) res = QNAN_DEFAULT;
      else if (ia || ic) res = {s_p, EXP_ALL1, 52'h0};
      else if (is_fma && ib) res = {s_b, EXP_ALL1, 52'h0};
      else {ovf, res} = pk;
    end
    if (is_mov) begin
      inv  = 1'b0;
      zdiv = 1'b0;
      ovf  = 1'b0;
      res  = r_reg.opb;
    end
    trap = (inv && r_reg.fp_status_control_reg[VE_BIT]) ||
           (zdiv && r_reg.fp_status_control_reg[ZE_BIT]);
  end

  // ------------------------------------------------------------------
  // sequencer and register port
  // ------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.wbv = 1'b0;
    r_next.ill = 1'b0;
    r_next.rdata = 32'h0;
    mem_we = fpr_load_en;
    mem_wi = fpr_load_idx;
    mem_wd = fpr_load_data;
    if (reg_wr && reg_addr == REG_FP_STATUS_CONTROL_REG) begin
      r_next.fp_status_control_reg = reg_wdata;
    end
    case (r_reg.st)
      ST_IDLE: begin
        if (issue_valid && legal) begin
          r_next.instr = issue_instr;
          r_next.st = ST_RDA;
          r_next.ready = 1'b0;
        end else if (issue_valid) begin
          r_next.ill = 1'b1;
        end
      end
      ST_RDA: begin
        r_next.opa = rd_data;
        r_next.st = ST_RDB;
      end
      ST_RDB: begin
        r_next.opb = rd_data;
        r_next.st = ST_RDC;
      end
      ST_RDC: begin
        r_next.opc = rd_data;
        r_next.st = ST_EXEC;
      end
      ST_EXEC: begin
        r_next.st = ST_IDLE;
        r_next.ready = 1'b1;
        if (!is_mov) begin
          // sticky exception bits; hardware set wins over a bus clear
          if (inv) r_next.fp_status_control_reg[VX_BIT] = 1'b1;
          if (zdiv) r_next.fp_status_control_reg[ZX_BIT] = 1'b1;
          if (ovf) r_next.fp_status_control_reg[OX_BIT] = 1'b1;
          if (inv || zdiv || ovf) begin
            r_next.fp_status_control_reg[FX_BIT] = 1'b1;
          end
          // divide class flags held on trap
          // multiply class flags held on trap
          if (!trap) begin
            r_next.fp_status_control_reg[RESULT_CLASS_FLAGS_LSB +: 5] = fclass(res);
          end
        end
        if (!trap) begin
          mem_we = 1'b1;
          mem_wi = f_d;
          mem_wd = res;
          r_next.wbv = 1'b1;
          r_next.wbi = f_d;
          r_next.wbd = res;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
        r_next.ready = 1'b1;
      end
    endcase
    r_next.fp_status_control_reg[FEX_BIT] =
      (r_next.fp_status_control_reg[VX_BIT] &
       r_next.fp_status_control_reg[VE_BIT]) |
      (r_next.fp_status_control_reg[ZX_BIT] &
       r_next.fp_status_control_reg[ZE_BIT]);
    if (r_reg.st == ST_EXEC && f_rc) begin
      r_next.cf1 = r_next.fp_status_control_reg[FX_BIT -: 4];
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_FP_STATUS_CONTROL_REG:  r_next.rdata = r_reg.fp_status_control_reg;
        REG_COND:   r_next.rdata = {28'h0, r_reg.cf1};
        REG_STATUS: r_next.rdata = {31'h0, ~r_reg.ready};
        default:    r_next.rdata = 32'h0;
      endcase
    end
  end

  always_comb begin
    case (r_next.st)
      // index leads its word by one cycle: A, then B, then C
      ST_RDA:  rd_idx = f_a;
      ST_RDB:  rd_idx = f_b;
      ST_RDC:  rd_idx = f_c;
      default: rd_idx = f_a;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg <= '{st: ST_IDLE, fp_status_control_reg: FP_STATUS_CONTROL_REG_RESET,
                 ready: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign issue_ready         = r_reg.ready;
  assign reg_rdata           = r_reg.rdata;
  assign wb_valid            = r_reg.wbv;
  assign wb_idx              = r_reg.wbi;
  assign wb_data             = r_reg.wbd;
  assign condition_field_one = r_reg.cf1;
  assign illegal_op          = r_reg.ill;

endmodule

// ---- dv/fdmu_unit_properties.sv ----
// port-level checks on the divide/multiply datapath
`timescale 1ns/1ns
module fdmu_unit_checker (
  input  wire logic        clk,                 // core clock
  input  wire logic        rst_b,               // sync reset
  input  wire logic        issue_valid,         // instr offered
  input  wire logic        issue_ready,         // idle
  input  wire logic        reg_rd,              // read strobe
  input  wire logic [7:0]  reg_addr,            // reg address
  input  wire logic [31:0] reg_rdata,           // read data
  input  wire logic        wb_valid,            // target wrote
  input  wire logic [4:0]  wb_idx,              // target index
  input  wire logic [63:0] wb_data,             // target value
  input  wire logic [3:0]  condition_field_one, // cf1
  input  wire logic        illegal_op           // bad encoding
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_wb_pulse; wb_valid |=> !wb_valid; endproperty
  a_wb_pulse: assert property (p_wb_pulse)
    else $error("writeback pulse too long");
  property p_busy; $fell(issue_ready) |-> !issue_ready [*4] ##1 issue_ready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy span wrong");
  property p_wb_lat;
    wb_valid |-> issue_ready && !$past(issue_ready) && $past(issue_ready, 5);
  endproperty
  a_wb_lat: assert property (p_wb_lat)
    else $error("writeback latency wrong");
  property p_illegal; illegal_op |-> $past(issue_valid) && issue_ready;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal flag without offer");
  property p_cf1; $changed(condition_field_one) |-> $rose(issue_ready);
  endproperty
  a_cf1: assert property (p_cf1)
    else $error("cf1 changed mid-operation");
  property p_hold; !wb_valid |-> $stable(wb_data) && $stable(wb_idx);
  endproperty
  a_hold: assert property (p_hold)
    else $error("target changed without writeback");
  // read data only in its slot
  property p_rzero; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rzero: assert property (p_rzero)
    else $error("read data outside read slot");
  property p_rcond;
    reg_rd && reg_addr == 8'h04 |=>
      reg_rdata == {28'h0, $past(condition_field_one)};
  endproperty
  a_rcond: assert property (p_rcond)
    else $error("cf1 readback wrong");
  c_wb: cover property (wb_valid);
  c_ill: cover property (illegal_op);
  c_cf1: cover property ($changed(condition_field_one));
endmodule

// ---- dv/fdmu_issue_model.sv ----
// instruction issue and register file preload model
`timescale 1ns/1ns
module fdmu_issue_model (
  input  wire logic        clk,           // core clock
  input  wire logic        issue_ready,   // datapath idle
  output logic             issue_valid,   // instr offered
  output logic [31:0]      issue_instr,   // instr word
  output logic             fpr_load_en,   // preload strobe
  output logic [4:0]       fpr_load_idx,  // preload index
  output logic [63:0]      fpr_load_data  // preload data
);
  initial begin
    issue_valid = 1'b0;
    issue_instr = 32'h0;
    fpr_load_en = 1'b0;
    fpr_load_idx = 5'h00;
    fpr_load_data = 64'h0;
  end
  task automatic load(input logic [4:0] i, input logic [63:0] d);
    @(posedge clk);
    fpr_load_en <= 1'b1;
    fpr_load_idx <= i;
    fpr_load_data <= d;
    @(posedge clk);
    fpr_load_en <= 1'b0;
    fpr_load_data <= ~d;
  endtask
  task automatic offer(input logic [31:0] w);
    logic r;
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_instr <= w;
    forever begin
      @(negedge clk);
      r = issue_ready;
      @(posedge clk);
      if (r) break;
    end
    issue_valid <= 1'b0;
    issue_instr <= ~w;
  endtask
endmodule

// ---- dv/fdmu_unit_tb.sv ----
// self-checking bench for the divide/multiply datapath
`timescale 1ns/1ns
module fdmu_unit_tb;
  import fdmu_pkg::*;
  logic        clk, rst_b, reg_wr, reg_rd, issue_valid, issue_ready;
  logic        fpr_load_en, wb_valid, illegal_op;
  logic [31:0] issue_instr, reg_wdata, reg_rdata;
  logic [7:0]  reg_addr;
  logic [4:0]  fpr_load_idx, wb_idx;
  logic [63:0] fpr_load_data, wb_data;
  logic [3:0]  cf1;
  int          fails, samples_checked;
  logic [4:0]  xo_t[4] = '{XO_DIV, XO_MUL, XO_MADD, XO_MSUB};
  logic [63:0] res_t[4] = '{64'h4000_0000_0000_0000, 64'h4018_0000_0000_0000,
                            64'h401E_0000_0000_0000, 64'h4012_0000_0000_0000};
  logic [63:0] rr_t[5] = '{64'h3FD5_5555_5555_5555, 64'h3FD5_5555_6000_0000,
                           64'h3FD5_5555_5555_5556, 64'h3FD5_5555_4000_0000,
                           64'h3FD5_5555_5555_5555};
  logic [1:0]  rn_t[5] = '{RN_NEAR, RN_NEAR, RN_PINF, RN_ZERO, RN_MINF};
  fdmu_unit i_dut (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .issue_ready(issue_ready),
    .fpr_load_en(fpr_load_en), .fpr_load_idx(fpr_load_idx),
    .fpr_load_data(fpr_load_data), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wb_valid(wb_valid), .wb_idx(wb_idx),
    .wb_data(wb_data), .condition_field_one(cf1), .illegal_op(illegal_op));
  fdmu_issue_model i_model (.clk(clk), .issue_ready(issue_ready),
    .issue_valid(issue_valid), .issue_instr(issue_instr),
    .fpr_load_en(fpr_load_en), .fpr_load_idx(fpr_load_idx),
    .fpr_load_data(fpr_load_data));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] mk(input logic [5:0] op,
    input logic [4:0] d, a, b, c, xo, input logic rc);
    return {op, d, a, b, c, xo, rc};
  endfunction
  task automatic chk(input logic [63:0] g, e, input string m);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, m);
  endtask
  task automatic exec(input logic [31:0] w, input logic [63:0] e);
    i_model.offer(w);
    repeat (4) @(posedge clk);
    #1 chk(wb_valid, 1, "wb");
    chk(wb_data, e, "data");
    chk(wb_idx, w[25:21], "idx");
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000 fails++;
    wrap_up;
  end
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    i_model.load(5'h01, 64'h4008_0000_0000_0000);
    i_model.load(5'h02, 64'h3FF8_0000_0000_0000);
    i_model.load(5'h03, 64'h4000_0000_0000_0000);
    i_model.load(5'h04, 64'h0);
    i_model.load(5'h05, 64'h3FF0_0000_0000_0000);
    i_model.load(5'h06, 64'h7FF4_0000_0000_0001);
    rd(REG_FP_STATUS_CONTROL_REG, 32'h0, "status reset");
    rd(8'h10, 32'h0, "unmapped");
    rd(REG_STATUS, 32'h0, "idle status");
    wr(REG_COND, 32'hF);
    rd(REG_COND, 32'h0, "read-only");
    $display("test register port done");
    for (int i = 0; i < 8; i++)
      exec(mk(i[0] ? OP_SINGLE : OP_DOUBLE, 5'(10 + i), 5'h01,
        (i / 2 == 1) ? 5'h00 : 5'h02, (i < 2) ? 5'h00 : 5'h03, xo_t[i / 2],
        1'b0), res_t[i / 2]);
    rd(REG_FP_STATUS_CONTROL_REG, 32'h0000_4000, "class");
    exec(mk(OP_DOUBLE, 5'd20, 5'h02, 5'h01, 5'h00, XO_DIV, 1'b0),
      64'h3FE0_0000_0000_0000);
    $display("test operation table done");
    for (int j = 0; j < 5; j++) begin
      wr(REG_FP_STATUS_CONTROL_REG, {30'h0, rn_t[j]});
      exec(mk(j[0] ? OP_SINGLE : OP_DOUBLE, 5'd21, 5'h05, 5'h01, 5'h00,
        XO_DIV, 1'b0), rr_t[j]);
    end
    $display("test rounding done");
    wr(REG_FP_STATUS_CONTROL_REG, 32'h0000_4010);
    i_model.offer(mk(OP_DOUBLE, 5'd22, 5'h01, 5'h04, 5'h00, XO_DIV, 1'b1));
    repeat (6) begin
      @(posedge clk);
      #1 chk(wb_valid, 0, "trap wb");
    end
    chk(cf1, 4'hC, "cf1 trap");
    rd(REG_FP_STATUS_CONTROL_REG, 32'hC400_4010, "trap status");
    wr(REG_FP_STATUS_CONTROL_REG, 32'h0);
    exec(mk(OP_DOUBLE, 5'd23, 5'h01, 5'h04, 5'h00, XO_DIV, 1'b1),
      64'h7FF0_0000_0000_0000);
    chk(cf1, 4'h8, "cf1 zdiv");
    rd(REG_FP_STATUS_CONTROL_REG, 32'h8400_5000, "zdiv status");
    wr(REG_FP_STATUS_CONTROL_REG, 32'h0000_0080);
    i_model.offer(mk(OP_DOUBLE, 5'd26, 5'h06, 5'h00, 5'h01, XO_MUL, 1'b1));
    repeat (6) @(posedge clk);
    #1 chk(wb_idx, 5'd23, "invalid trap wb");
    chk(cf1, 4'hE, "cf1 invalid");
    rd(REG_FP_STATUS_CONTROL_REG, 32'hE000_0080, "invalid status");
    $display("test zero divide done");
    wr(REG_FP_STATUS_CONTROL_REG, 32'h0000_5000);
    exec(mk(OP_DOUBLE, 5'd24, 5'h00, 5'h06, XO_MOVE[9:5], XO_MOVE[4:0],
      1'b1), 64'h7FF4_0000_0000_0001);
    chk(cf1, 4'h0, "cf1 move");
    rd(REG_FP_STATUS_CONTROL_REG, 32'h0000_5000, "move status");
    $display("test move done");
    i_model.offer(mk(OP_DOUBLE, 5'd25, 5'h01, 5'h02, 5'h01, XO_DIV, 1'b0));
    #1 chk(illegal_op, 1, "div c field");
    i_model.offer(mk(OP_DOUBLE, 5'd25, 5'h01, 5'h02, 5'h03, XO_MUL, 1'b0));
    #1 chk(illegal_op, 1, "mul b field");
    $display("test illegal done");
    wrap_up;
  end
endmodule
bind fdmu_unit fdmu_unit_checker i_chk (.clk(clk), .rst_b(rst_b),
  .issue_valid(issue_valid), .issue_ready(issue_ready), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .wb_valid(wb_valid),
  .wb_idx(wb_idx), .wb_data(wb_data),
  .condition_field_one(condition_field_one), .illegal_op(illegal_op));
